/* File: src/adt_pkg.sv */
// Overview of operation
// - Two modes: program control via accumulator, or data channel straight to memory.
// - Status bit 10 set selects sequential data-channel operation.
// - Status bit 10 clear selects random operation, one status word per conversion.
// - Host count overflow sets the word-count flag, which requests an interrupt.
// - Sequential mode reuses one status word, converting channels back to back.
// - Sequential mode: one three-cycle break per converted word, device to memory.
// - Random mode: a result break, then a status-fetch break, per word.
// - Status bit 9 enables add-to-memory; sum sign overflow sets memory flag.
// - Memory flag interrupts only when status bit 6 is set.
// - Interrupt sources: done in program mode, memory overflow, word-count overflow.
// - Word-count flag drives both program and level-0 priority requests.
// - Done, word-count and memory flags are separately testable.
// - Result stays buffered until the next conversion overwrites it.
// - Memory flag set blocks a finished conversion from loading the buffer.
// - Sequential data channel increments channel address when word-count flag clear.
// - Trigger waits 3.0 us settling before the converter start pulse.
// - Inbound break loads status unless word-count flag or add-to-memory.
package adt_pkg;
   localparam int WORD_W = 18;
   localparam int DATA_W = 13;
   localparam int CHAN_W = 7;
   localparam int ADDR_W = 4;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_RESULT = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_FLAGS = 4'h8;
   // ------------------------------------------------------------
   // Status word fields, host bit n sits at position 17-n
   // ------------------------------------------------------------
   localparam int BIT_SEQ = 7;
   localparam int BIT_ADDMEM = 8;
   localparam int BIT_DCH = 9;
   localparam int BIT_EXTSYNC = 10;
   localparam int BIT_MEMIE = 11;
   localparam int BIT_GAIN_LO = 12;
   // Flags register positions
   localparam int FLG_DONE = 0;
   localparam int FLG_WC = 1;
   localparam int FLG_MEM = 2;
   localparam int FLG_PRIO = 3;
   localparam int FLG_CHAN_LO = 4;
   localparam logic [WORD_W-1:0] CONTROL_RESET = 18'h00000;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLOCK_NS = 10;
   localparam int SETTLE_NS = 3000;
   localparam int SETTLE_CYC = (SETTLE_NS + CLOCK_NS - 1) / CLOCK_NS;
   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_ARM = 5'h02,
      S_SETTLE = 5'h04,
      S_CONVERT = 5'h08,
      S_FETCH = 5'h10
   } adt_state_e_t;
   typedef struct packed {
      logic hostToDevicePulse;
      logic deviceToHostPulse;
      logic readSig;
      logic writeSig;
      logic hostCountOverflow;
      logic sumSignOverflowPulse;
      logic [WORD_W-1:0] data;
   } adt_host_in_t;
   typedef struct packed {
      logic dchRequest;
      logic dchFetch;
      logic [WORD_W-1:0] data;
      logic programInterruptRequest;
      logic priorityLevel0Request;
   } adt_host_out_t;
   typedef struct packed {
      logic adcDone;
      logic [DATA_W-1:0] adcData;
      logic extSync;
   } adt_conv_in_t;
   typedef struct packed {
      logic startPulse;
      logic [CHAN_W-1:0] channel;
      logic [1:0] gain;
   } adt_conv_out_t;
endpackage

/* File: src/adt_channel_transfer_control.sv */
`timescale 1ns/1ps
module adt_channel_transfer_control (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // Register port
   input wire logic [adt_pkg::ADDR_W-1:0] regAddr,
   input wire logic [adt_pkg::WORD_W-1:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [adt_pkg::WORD_W-1:0] regRdData,
   // Host bus and data channel
   input adt_pkg::adt_host_in_t hostIn,
   output adt_pkg::adt_host_out_t hostOut,
   // Converter and multiplexer
   input adt_pkg::adt_conv_in_t convIn,
   output adt_pkg::adt_conv_out_t convOut
);
   import adt_pkg::*;

   typedef struct packed {
      adt_state_e_t fsm;
      logic [8:0] settleCnt;
      logic [WORD_W-1:0] ctl;
      logic [CHAN_W-1:0] chan;
      logic [DATA_W-1:0] buffer;
      logic doneFlag;
      logic wcFlag;
      logic memFlag;
      logic resultPending;
      logic fetchPending;
      logic startPulse;
      logic dchReq;
      logic fetchOut;
      logic progIrq;
      logic prio0;
      logic [WORD_W-1:0] rdData;
   } adt_regs_t;

   logic [1:0] rstPipe;
   logic rstSync;
   adt_regs_t st;
   adt_regs_t nx;
   logic seqMode;
   logic dchMode;
   logic addMem;
   logic inboundLoad;

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rstPipe <= 2'h0;
      end else begin
         rstPipe <= {rstPipe[0], 1'b1};
      end
   end
   assign rstSync = rstPipe[1];

   assign seqMode = st.ctl[BIT_SEQ];
   assign dchMode = st.ctl[BIT_DCH];
   assign addMem = st.ctl[BIT_ADDMEM];
   // A break carrying both read and write is an add-to-memory cycle
   assign inboundLoad = hostIn.hostToDevicePulse && dchMode && !st.wcFlag
      && !(hostIn.readSig && hostIn.writeSig);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      nx = st;
      nx.startPulse = 1'b0;
      nx.rdData = '0;

      // Flags: set wins over clear
      if (regWrite && regAddr == OFS_FLAGS) begin
         if (regWrData[FLG_DONE]) nx.doneFlag = 1'b0;
         if (regWrData[FLG_WC]) nx.wcFlag = 1'b0;
         if (regWrData[FLG_MEM]) nx.memFlag = 1'b0;
      end
      if (regRead && regAddr == OFS_RESULT) begin
         nx.doneFlag = 1'b0;
      end
      if (hostIn.hostCountOverflow) begin
         nx.wcFlag = 1'b1;
      end
      if (hostIn.sumSignOverflowPulse && addMem) begin
         nx.memFlag = 1'b1;
      end

      // Result leaves on the outbound break
      if (hostIn.deviceToHostPulse) begin
         nx.resultPending = 1'b0;
      end

      case (st.fsm)
         S_IDLE: begin
            nx.settleCnt = '0;
         end
         S_ARM: begin
            nx.settleCnt = '0;
            if (!st.ctl[BIT_EXTSYNC] || convIn.extSync) begin
               nx.fsm = S_SETTLE;
            end
         end
         S_SETTLE: begin
            nx.settleCnt = st.settleCnt + 9'h001;
            if (st.settleCnt == 9'(SETTLE_CYC - 1)) begin
               nx.startPulse = 1'b1;
               nx.fsm = S_CONVERT;
            end
         end
         S_CONVERT: begin
            if (convIn.adcDone) begin
               // Keep the addend so software can rebuild the old sum
               if (!st.memFlag) begin
                  nx.buffer = convIn.adcData;
               end
               if (dchMode) begin
                  nx.resultPending = 1'b1;
                  if (st.wcFlag) begin
                     nx.fsm = S_IDLE;
                  end else if (seqMode) begin
                     nx.chan = st.chan + 7'h01;
                     nx.fsm = S_ARM;
                  end else begin
                     nx.fetchPending = 1'b1;
                     nx.fsm = S_FETCH;
                  end
               end else begin
                  nx.doneFlag = 1'b1;
                  nx.fsm = S_IDLE;
               end
            end
         end
         S_FETCH: begin
            if (st.wcFlag) begin
               nx.fetchPending = 1'b0;
               nx.fsm = S_IDLE;
            end
         end
         default: begin
            nx.fsm = S_IDLE;
         end
      endcase

      // Status word from a break, random mode
      if (inboundLoad && st.fetchPending) begin
         nx.ctl = hostIn.data;
         nx.chan = hostIn.data[CHAN_W-1:0];
         nx.fetchPending = 1'b0;
         nx.fsm = S_ARM;
      end

      // Status word from software starts a conversion in either mode
      if (regWrite && regAddr == OFS_CONTROL) begin
         nx.ctl = regWrData;
         nx.chan = regWrData[CHAN_W-1:0];
         nx.fetchPending = 1'b0;
         nx.fsm = S_ARM;
      end

      nx.dchReq = nx.resultPending || nx.fetchPending;
      // Result break goes first so a fetch cannot overrun the buffer
      nx.fetchOut = nx.fetchPending && !nx.resultPending;
      // Priority flag follows the word-count flag onto both lines
      nx.prio0 = nx.wcFlag;
      nx.progIrq = nx.wcFlag || (nx.memFlag && nx.ctl[BIT_MEMIE])
         || (nx.doneFlag && !nx.ctl[BIT_DCH]);

      if (regRead) begin
         case (regAddr)
            OFS_CONTROL: nx.rdData = st.ctl;
            OFS_RESULT: nx.rdData = {{(WORD_W-DATA_W){st.buffer[DATA_W-1]}}, st.buffer};
            OFS_FLAGS: begin
               nx.rdData[FLG_DONE] = st.doneFlag;
               nx.rdData[FLG_WC] = st.wcFlag;
               nx.rdData[FLG_MEM] = st.memFlag;
               nx.rdData[FLG_PRIO] = st.prio0;
               nx.rdData[FLG_CHAN_LO +: CHAN_W] = st.chan;
            end
            default: nx.rdData = '0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge rstSync) begin
      if (!rstSync) begin
         st <= '{fsm: S_IDLE, ctl: CONTROL_RESET, default: '0};
      end else begin
         st <= nx;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign regRdData = st.rdData;
   assign hostOut.dchRequest = st.dchReq;
   assign hostOut.dchFetch = st.fetchOut;
   assign hostOut.data = {{(WORD_W-DATA_W){st.buffer[DATA_W-1]}}, st.buffer};
   assign hostOut.programInterruptRequest = st.progIrq;
   assign hostOut.priorityLevel0Request = st.prio0;
   assign convOut.startPulse = st.startPulse;
   assign convOut.channel = st.chan;
   assign convOut.gain = st.ctl[BIT_GAIN_LO +: 2];

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstSync);

   property p_settle;
      st.fsm == S_SETTLE && st.settleCnt == 9'h000 && !regWrite && !hostIn.hostToDevicePulse
         |-> ##300 st.startPulse;
   endproperty
   a_settle: assert property (p_settle) else $error("start pulse not 3 us after trigger");

   property p_seqIncr;
      st.fsm == S_CONVERT && convIn.adcDone && dchMode && seqMode && !st.wcFlag
         && !regWrite |=> st.chan == $past(st.chan) + 7'h01 && st.fsm == S_ARM;
   endproperty
   a_seqIncr: assert property (p_seqIncr) else $error("channel not advanced");

   property p_bufHold;
      st.memFlag && convIn.adcDone |=> $stable(st.buffer);
   endproperty
   a_bufHold: assert property (p_bufHold) else $error("buffer loaded under memory flag");

   property p_prio;
      hostIn.hostCountOverflow |=> st.wcFlag ##0 hostOut.priorityLevel0Request
         ##0 hostOut.programInterruptRequest;
   endproperty
   a_prio: assert property (p_prio) else $error("count overflow did not interrupt");

   property p_memMask;
      st.memFlag && !st.ctl[BIT_MEMIE] && !st.wcFlag && !st.doneFlag |-> !st.progIrq;
   endproperty
   a_memMask: assert property (p_memMask) else $error("masked memory flag interrupted");

   property p_memSet;
      hostIn.sumSignOverflowPulse && addMem |=> st.memFlag;
   endproperty
   a_memSet: assert property (p_memSet) else $error("memory flag not set");

   property p_noAddLoad;
      hostIn.hostToDevicePulse && hostIn.readSig && hostIn.writeSig && !regWrite
         |=> $stable(st.ctl);
   endproperty
   a_noAddLoad: assert property (p_noAddLoad) else $error("add cycle loaded status");

   property p_randFetch;
      st.fsm == S_CONVERT && convIn.adcDone && dchMode && !seqMode && !st.wcFlag
         && !regWrite |=> st.fetchPending ##1 hostOut.dchRequest;
   endproperty
   a_randFetch: assert property (p_randFetch) else $error("no status fetch requested");

   property p_dchReq;
      st.resultPending |-> hostOut.dchRequest;
   endproperty
   a_dchReq: assert property (p_dchReq) else $error("result without request");

   property p_progDone;
      st.fsm == S_CONVERT && convIn.adcDone && !dchMode && !regWrite
         |=> st.doneFlag && hostOut.programInterruptRequest;
   endproperty
   a_progDone: assert property (p_progDone) else $error("done did not interrupt");

   c_seq: cover property (st.fsm == S_CONVERT && convIn.adcDone && seqMode && dchMode);
   c_rand: cover property (inboundLoad && st.fetchPending);
   c_mem: cover property (st.memFlag && convIn.adcDone);
   c_wc: cover property (hostIn.hostCountOverflow && st.fsm == S_SETTLE);
endmodule // adt_channel_transfer_control

/* File: tb/adt_host_model.sv */
`timescale 1ns/1ps
module adt_host_model (
   // Bus toward the device
   input wire logic clock,
   input adt_pkg::adt_host_out_t hostOut,
   output adt_pkg::adt_host_in_t hostIn,
   // Scenario control
   input wire logic restart,
   input wire logic [7:0] wanted,
   input wire logic [6:0] seed,
   input wire logic [3:0] lag,
   input wire logic sumOflo,
   output logic [7:0] outCount,
   output logic [7:0] inCount
);
   import adt_pkg::*;
   // Vector taken when the level-0 request is honoured, 57 octal
   localparam logic [WORD_W-1:0] TRAP_VEC = 18'h0002f;
   logic [WORD_W-1:0] results [0:63];
   logic [WORD_W-1:0] trapAddr;
   logic [4:0] waitCnt;
   logic inGo;
   logic outGo;
   // ------------------------------------------------------------
   // Break engine
   // ------------------------------------------------------------
   initial begin
      hostIn = '0;
      outCount = '0;
      inCount = '0;
      waitCnt = '0;
      trapAddr = '0;
   end
   always @(posedge clock) begin
      inGo = !restart && waitCnt == 5'h00 && hostOut.dchRequest === 1'b1
         && hostOut.dchFetch === 1'b1;
      outGo = !restart && waitCnt == 5'h00 && hostOut.dchRequest === 1'b1 && !inGo;
      // Add-to-memory cycle: inbound pulse with read and write together
      hostIn.hostToDevicePulse <= inGo || sumOflo;
      hostIn.readSig <= sumOflo;
      hostIn.writeSig <= sumOflo;
      hostIn.deviceToHostPulse <= outGo;
      hostIn.hostCountOverflow <= outGo && (outCount + 8'h01 == wanted);
      hostIn.sumSignOverflowPulse <= sumOflo;
      if (inGo) begin
         hostIn.data <= (18'(inCount[1:0]) << BIT_GAIN_LO) | (18'h1 << BIT_DCH)
            | 18'(7'(seed + 3 * inCount));
      end else begin
         hostIn.data <= ~hostIn.data; // Released bus never keeps a stale word
      end
      if (restart) begin
         outCount <= '0;
         inCount <= '0;
         waitCnt <= 5'(lag);
      end else if (waitCnt != 5'h00) begin
         waitCnt <= waitCnt - 5'h01;
      end else if (inGo) begin
         inCount <= inCount + 8'h01;
         waitCnt <= 5'(lag) + 5'h02; // Pause lets the request drop first
      end else if (outGo) begin
         results[outCount[5:0]] <= hostOut.data;
         outCount <= outCount + 8'h01;
         waitCnt <= 5'(lag) + 5'h02;
      end
      // Level 0 outranks the general request
      if (hostOut.priorityLevel0Request === 1'b1) begin
         trapAddr <= TRAP_VEC;
      end else if (hostOut.programInterruptRequest === 1'b1) begin
         trapAddr <= 18'h00000;
      end
   end
endmodule // adt_host_model

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import adt_pkg::*;
   logic clock, rst_b, regWrite, regRead, restart, sumOflo;
   logic [ADDR_W-1:0] regAddr;
   logic [WORD_W-1:0] regWrData, regRdData, v;
   adt_host_in_t hostIn;
   adt_host_out_t hostOut;
   adt_conv_in_t convIn;
   adt_conv_out_t convOut;
   logic [7:0] wanted, outCount, inCount;
   logic [6:0] seed;
   logic [3:0] lag;
   logic [12:0] convQ [$];
   logic [8:0] chanQ [$];
   logic [12:0] d;
   int cdel = 0;
   int n;
   int failures = 0;
   int numChecks = 0;
   adt_channel_transfer_control u_adt_channel_transfer_control (
      .clock(clock), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .hostIn(hostIn), .hostOut(hostOut), .convIn(convIn), .convOut(convOut));
   adt_host_model u_adt_host_model (
      .clock(clock), .hostOut(hostOut), .hostIn(hostIn), .restart(restart),
      .wanted(wanted), .seed(seed), .lag(lag), .sumOflo(sumOflo),
      .outCount(outCount), .inCount(inCount));
   // ------------------------------------------------------------
   // Converter stand-in, fixed conversion time
   // ------------------------------------------------------------
   always @(posedge clock) begin
      convIn.adcDone <= 1'b0;
      if (cdel != 0) cdel <= cdel - 1;
      if (convOut.startPulse === 1'b1) begin
         cdel <= 20;
         chanQ.push_back({convOut.gain, convOut.channel});
      end else if (cdel == 1) begin
         d = 13'($urandom);
         convIn.adcData <= d;
         convIn.adcDone <= 1'b1;
         convQ.push_back(d);
      end
   end
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic chk(input string what, input logic [17:0] seen, input logic [17:0] exp);
      numChecks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [17:0] w);
      @(posedge clock);
      regAddr <= a;
      regWrData <= w;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      #1;
      v = regRdData;
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge clock);
      #1;
   endtask
   task automatic wait_conv(input int want);
      for (int i = 0; i < 2000 && convQ.size() < want; i++) @(posedge clock);
      tick(3);
   endtask
   function automatic logic [17:0] sext(input logic [12:0] x);
      return {{5{x[12]}}, x};
   endfunction
   // Mode nibble is memory irq enable, data channel, add-to-memory, sequential
   function automatic logic [17:0] ctl(logic [6:0] ch, logic [1:0] g, logic [3:0] m);
      ctl = 18'h0;
      ctl[6:0] = ch;
      ctl[BIT_GAIN_LO +: 2] = g;
      {ctl[BIT_MEMIE], ctl[BIT_DCH], ctl[BIT_ADDMEM], ctl[BIT_SEQ]} = m;
   endfunction
   function automatic logic [8:0] exp_chan(logic s, logic [6:0] ch, logic [1:0] g, int k);
      if (s) return {g, 7'(ch + k)};
      if (k == 0) return {g, ch};
      return {2'(k - 1), 7'(seed + 3 * (k - 1))};
   endfunction
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic prog_test(input logic [6:0] ch, input logic [1:0] g, input logic ext);
      int base;
      base = convQ.size();
      wr(OFS_CONTROL, ctl(ch, g, 4'h0) | (18'(ext) << BIT_EXTSYNC));
      // External trigger: stay armed a while, then one sync pulse starts the settle
      if (ext) begin
         repeat (20) @(posedge clock);
         convIn.extSync <= 1'b1;
         @(posedge clock);
         convIn.extSync <= 1'b0;
      end
      for (n = 1; n < 400; n++) begin
         tick(1);
         if (convOut.startPulse === 1'b1) break;
      end
      chk("settle", n, 18'(ext ? SETTLE_CYC : SETTLE_CYC + 1));
      chk("mux", {convOut.gain, convOut.channel}, {g, ch});
      wait_conv(base + 1);
      chk("done irq", hostOut.programInterruptRequest, 1);
      chk("no break", hostOut.dchRequest, 0);
      rd(OFS_FLAGS);
      chk("flags", {v[10:4], v[FLG_DONE]}, {ch, 1'b1});
      rd(OFS_RESULT);
      chk("result", v, sext(convQ[base]));
      tick(2);
      chk("irq clear", hostOut.programInterruptRequest, 0);
      $display("program transfer test done");
   endtask
   task automatic mem_test();
      logic [17:0] keep;
      int base;
      base = convQ.size();
      wr(OFS_CONTROL, ctl(7'h05, 2'h1, 4'h2));
      wait_conv(base + 1);
      rd(OFS_RESULT);
      keep = v;
      sumOflo <= 1'b1;
      @(posedge clock);
      sumOflo <= 1'b0;
      tick(3);
      chk("masked irq", hostOut.programInterruptRequest, 0);
      rd(OFS_FLAGS);
      chk("mem flag", v[FLG_MEM], 1);
      wr(OFS_CONTROL, ctl(7'h06, 2'h1, 4'ha));
      tick(3);
      chk("mem irq", hostOut.programInterruptRequest, 1);
      wait_conv(base + 2);
      rd(OFS_RESULT);
      chk("held result", v, keep);
      wr(OFS_FLAGS, 18'h7);
      $display("add-to-memory test done");
   endtask
   task automatic dch_test(input logic s);
      logic [6:0] ch;
      logic [1:0] g;
      int base;
      ch = 7'($urandom);
      g = 2'($urandom);
      base = convQ.size();
      @(posedge clock);
      restart <= 1'b1;
      seed <= 7'($urandom);
      lag <= 4'($urandom);
      wanted <= 8'(2 + $urandom % 3);
      @(posedge clock);
      restart <= 1'b0;
      wr(OFS_CONTROL, ctl(ch, g, {3'b010, s}));
      for (n = 0; n < 9000 && hostOut.priorityLevel0Request !== 1'b1; n++) @(posedge clock);
      tick(400);
      chk("irq pair", {hostOut.programInterruptRequest, hostOut.priorityLevel0Request},
         2'b11);
      chk("trap", u_adt_host_model.trapAddr, 18'h0002f);
      // Sequential: the conversion already settling at count overflow still delivers
      chk("breaks out", outCount, wanted + 8'(s));
      chk("breaks in", inCount, s ? 8'h0 : wanted - 8'h1);
      chk("conversions", convQ.size() - base, wanted + 8'(s));
      for (int k = 0; k < wanted; k++) begin
         chk("stored", u_adt_host_model.results[k], sext(convQ[base + k]));
         chk("channel", chanQ[base + k], exp_chan(s, ch, g, k));
      end
      rd(OFS_FLAGS);
      chk("wc flags", v[3:1], 3'b101);
      wr(OFS_FLAGS, 18'h7);
      tick(3);
      chk("prio clear", hostOut.priorityLevel0Request, 0);
      $display("data channel test done");
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", numChecks, failures);
      if (failures == 0 && numChecks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      #400000;
      failures++;
      stop_test();
   end
   initial begin
      {rst_b, regWrite, regRead, restart, sumOflo} = 5'h00;
      regAddr = '0;
      regWrData = '0;
      convIn = '0;
      wanted = 8'h2;
      seed = 7'h00;
      lag = 4'h0;
      void'($urandom(76));
      repeat (4) @(posedge clock);
      rst_b <= 1'b1;
      repeat (3) @(posedge clock);
      rd(OFS_CONTROL);
      chk("control reset", v, CONTROL_RESET);
      rd(4'h2);
      chk("unmapped", v, 0);
      prog_test(7'h7f, 2'h3, 1'b0);
      prog_test(7'($urandom), 2'($urandom), 1'b1);
      mem_test();
      dch_test(1'b1);
      dch_test(1'b0);
      stop_test();
   end
endmodule // tb_top
